// [verilog/cmc_pkg.sv]
// constants and types of the protocol mode controller
package cmc_pkg;
	// register indices
	localparam logic [3:0] A_ISR  = 4'h0;
	localparam logic [3:0] A_ICR  = 4'h1;
	localparam logic [3:0] A_CSR  = 4'h2;
	localparam logic [3:0] A_PRE  = 4'h3;
	localparam logic [3:0] A_BTR  = 4'h4;
	localparam logic [3:0] A_PAGE = 4'h5;
	localparam logic [3:0] A_TEC  = 4'h6;
	localparam logic [3:0] A_REC  = 4'h7;
	localparam logic [3:0] A_LIDH = 4'h8;
	localparam logic [3:0] A_LIDL = 4'h9;
	localparam logic [3:0] A_BCS1 = 4'hA;
	localparam logic [3:0] A_LAST = 4'hD;
	// interrupt flag bits
	localparam int F_RECEIVE_FLAG = 5;
	localparam int F_TRANSMIT_DONE_FLAG = 4;
	localparam int F_SCIF = 3;
	localparam int F_ORIF = 2;
	localparam int F_TRANSMIT_ERROR_FLAG = 1;
	// interrupt control bits
	localparam int C_ESCI = 6;
	localparam int C_RECEIVE_IRQ_ENABLE = 5;
	localparam int C_TRANSMIT_DONE_IRQ_ENABLE = 4;
	localparam int C_STATUS_CHANGE_IRQ_ENABLE = 3;
	localparam int C_OVERRUN_IRQ_ENABLE = 2;
	localparam int C_TRANSMIT_ERROR_IRQ_ENABLE = 1;
	localparam int C_ETX  = 0;
	// control/status bits
	localparam int S_BUS_OFF_STATUS = 6;
	localparam int S_ERROR_PASSIVE_STATUS = 5;
	// buffer control/status bits
	localparam int B_LOCK = 0;
	localparam int B_RDY  = 1;
	localparam int B_BUSY = 2;
	localparam int B_ACC  = 3;
	// bit timing fields
	localparam int P_RJW = 6;
	localparam int P_BRP = 5;
	localparam int T_BS2 = 4;
	localparam int T_BS1 = 3;
	// reset values
	localparam logic [7:0] BTR_RST = 8'h23;
	localparam logic [7:0] PRE_RST = 8'h00;
	// resync: last bit index of a recessive run, last sequence index
	localparam logic [3:0] RUN_LAST = 4'hA;
	localparam logic [7:0] SEQ_LAST = 8'h7F;
	// error counter steps and limits
	localparam logic [8:0] TEC_STEP = 9'h008;
	localparam logic [8:0] EP_LIM   = 9'h07F;
	localparam logic [8:0] BO_LIM   = 9'h0FF;
	localparam logic [7:0] REC_MAX  = 8'hFF;
	typedef enum logic [2:0] {ST_STANDBY, ST_WAKE, ST_RESYNC, ST_IDLE, ST_TX, ST_RX} cmc_state_t;
	typedef enum logic [1:0] {SG_SYNC, SG_ONE, SG_TWO} cmc_seg_t;
endpackage

// [verilog/cmc_mode_ctrl.sv]
// protocol mode controller: modes, bit timing, buffers, flags
// Contract
// RULE1: reset or cleared run enters standby, only after the current transfer ends
// RULE2: standby watches only for dominant bit, flags wake-up, interrupts if enabled
// RULE3: setting run goes to wake-up if wake pulse selected, else resync
// RULE4: messages are ignored until run set and synchronisation completed
// RULE5: wake-up drives the bus dominant for exactly one bit time
// RULE6: resync needs 128 runs of 11 recessive bits, or one if fast; code needs 128 in bus-off even if fast
// RULE7: idle reacts to run cleared, start of frame, last data byte write
// RULE8: software locks and reads back a buffer before submitting its job
// RULE9: on idle bus send pending buffer, 3 above 2 above 1
// RULE10: retry after loss or error until success, cancel or higher priority
// RULE11: busy flag held while transmitting; ready flag cleared at the end
// RULE12: success sets transmit done flag, failure transmit error flag, enables gate
// RULE13: early transmit flags on won arbitration, unlocks buffer after success
// RULE14: early transmit keeps arbitrating buffer until it wins; else highest priority
// RULE15: self receive enable lets own messages be received when accepted
// RULE16: accepted message stored in first buffer 1..3 with lock, ready clear
// RULE17: no free buffer raises overrun, identifier kept in last identifier
// RULE18: stored message records filter number, sets ready and receive flags
// RULE19: two readable error counters; status changes flag an interrupt
// RULE20: sample after segment one 1..16, segment two 1..8, jump 1..4
// RULE21: software keeps sync plus both segments at least 5 quanta
// RULE22: bit timing writes accepted only in standby
// RULE23: time quantum is clock period times prescaler plus one
// RULE24: hard sync on frame start edge, resync limited to jump width
`timescale 1ns/10ps
module cmc_mode_ctrl (
	input  wire logic        CLOCK,
	input  wire logic        NRST,
	input  wire logic [3:0]  ADDR,
	input  wire logic [7:0]  WR_DATA,
	input  wire logic        WR_EN,
	input  wire logic        RD_EN,
	output logic      [7:0]  RD_DATA,
	input  wire logic        CAN_RX,
	output logic             CAN_TX,
	output logic             IRQ,
	output logic             BIT_SAMPLE,
	output logic             RX_BIT,
	output logic             TX_START,
	output logic      [1:0]  TX_BUF,
	input  wire logic        FRM_TX_BIT,
	input  wire logic        FRM_ARB_WON,
	input  wire logic        FRM_ARB_LOST,
	input  wire logic        FRM_TX_OK,
	input  wire logic        FRM_TX_ERR,
	input  wire logic        FRM_RX_OK,
	input  wire logic        FRM_RX_ERR,
	input  wire logic        FRM_RX_OWN,
	input  wire logic        FRM_RX_FILT,
	input  wire logic [10:0] FRM_RX_ID,
	input  wire logic        FRM_END
);
	cmc_pkg::cmc_state_t state_ff;
	cmc_pkg::cmc_seg_t   seg_ff;
	logic [7:0]  icr_ff, pre_ff, btr_ff, tec_rd, rd_mux;
	logic [4:0]  csr_ff;          // self_receive_enable no_retransmission fast_sync_select wake_pulse_select run
	logic [2:0]  page_ff;
	logic        rx_meta_ff, rx_sync_ff, rx_prev_ff, edge_ff;
	logic [5:0]  tq_cnt_ff;
	logic [4:0]  cnt_ff, lim_ff, wk_cnt_ff;
	logic [3:0]  run_ff;
	logic [7:0]  seq_ff;
	logic [8:0]  tec_ff;
	logic [7:0]  rec_ff;
	logic [1:0]  stat_ff;
	logic [2:0]  lock_ff, rdy_ff, busy_ff, acc_ff, receive_flag_ff, job_ff;
	logic        transmit_done_flag_ff, scif_ff, orif_ff, transmit_error_flag_ff;
	logic [10:0] lid_ff;
	logic [1:0]  cur_ff, arm_buf_ff;
	logic        arm_ff;
	logic        bit_sample_ff, rx_bit_ff, can_tx_ff, irq_ff, tx_start_ff;
	logic [7:0]  rd_data_ff;
	// decoded fields and events
	logic [5:0] quantum_prescaler;
	logic [3:0] bs1;
	logic [2:0] bs2, rjw1;
	logic [4:0] rjw_w, lengthen, rem2;
	logic       self_receive_enable, no_retransmission, fast_sync_select, wake_pulse_select, run_req, early_transmit;
	logic       tq, fall, edge_now, hard, sample, wake_done, seq_done;
	logic       bus_off, err_psv, standby, in_tx, tx_ok, tx_err, store_ev;
	logic [2:0] pend, free;
	logic [1:0] sel, hi, first_free;
	logic       any_free, submit, wr_bcs;
	logic [1:0] wr_idx;

	assign quantum_prescaler     = pre_ff[cmc_pkg::P_BRP:0];
	assign rjw1    = {1'b0, pre_ff[cmc_pkg::P_RJW+1:cmc_pkg::P_RJW]} + 3'h1;
	assign bs1     = btr_ff[cmc_pkg::T_BS1:0];
	assign bs2     = btr_ff[cmc_pkg::T_BS2+2:cmc_pkg::T_BS2];
	assign {self_receive_enable, no_retransmission, fast_sync_select, wake_pulse_select, run_req} = csr_ff;
	assign early_transmit     = icr_ff[cmc_pkg::C_ETX];
	assign standby = (state_ff == cmc_pkg::ST_STANDBY);
	assign in_tx   = (state_ff == cmc_pkg::ST_TX);
	assign tx_ok   = in_tx && FRM_TX_OK;
	assign tx_err  = in_tx && FRM_TX_ERR;
	assign bus_off = (tec_ff > cmc_pkg::BO_LIM);
	assign err_psv = !bus_off && ((tec_ff > cmc_pkg::EP_LIM) || ({1'b0, rec_ff} > cmc_pkg::EP_LIM));

	// prescaler stopped in standby, one quantum per brp+1 clocks
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			tq_cnt_ff <= 6'h00;
		else if (standby || tq)
			tq_cnt_ff <= 6'h00; // RULE1
		else
			tq_cnt_ff <= tq_cnt_ff + 6'h01;
	end
	assign tq = !standby && (tq_cnt_ff == quantum_prescaler); // RULE23

	// bus line synchroniser and falling edge catch
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			rx_meta_ff <= 1'b1;
			rx_sync_ff <= 1'b1;
			rx_prev_ff <= 1'b1;
		end else begin
			rx_meta_ff <= CAN_RX;
			rx_sync_ff <= rx_meta_ff;
			rx_prev_ff <= rx_sync_ff;
		end
	end
	assign fall = rx_prev_ff && !rx_sync_ff;

	// edge held until the next quantum
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			edge_ff <= 1'b0;
		else if (tq)
			edge_ff <= 1'b0;
		else if (fall)
			edge_ff <= 1'b1;
	end
	assign edge_now = edge_ff || fall;
	assign hard     = (state_ff == cmc_pkg::ST_IDLE) || (state_ff == cmc_pkg::ST_RESYNC);
	assign rjw_w    = {2'b00, rjw1};
	assign lengthen = ((cnt_ff + 5'h01) > rjw_w) ? rjw_w : (cnt_ff + 5'h01);
	assign rem2     = {2'b00, bs2} - cnt_ff;
	assign sample   = tq && (seg_ff == cmc_pkg::SG_ONE) && (cnt_ff == lim_ff) && !edge_now;

	// bit segment sequencer with hard sync and jump-limited resync
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			seg_ff <= cmc_pkg::SG_SYNC;
			cnt_ff <= 5'h00;
			lim_ff <= 5'h00;
		end else if (standby) begin
			seg_ff <= cmc_pkg::SG_SYNC;
			cnt_ff <= 5'h00;
		end else if (tq) begin
			if (edge_now && hard) begin
				seg_ff <= cmc_pkg::SG_ONE; // RULE24
				cnt_ff <= 5'h00;
				lim_ff <= {1'b0, bs1};
			end else begin
				case (seg_ff)
					cmc_pkg::SG_SYNC: begin
						seg_ff <= cmc_pkg::SG_ONE;
						cnt_ff <= 5'h00;
						lim_ff <= {1'b0, bs1}; // RULE20
					end
					cmc_pkg::SG_ONE: begin
						if (edge_now) begin
							lim_ff <= {1'b0, bs1} + lengthen; // RULE24
							cnt_ff <= cnt_ff + 5'h01;
						end else if (cnt_ff == lim_ff) begin
							seg_ff <= cmc_pkg::SG_TWO; // RULE20
							cnt_ff <= 5'h00;
						end else
							cnt_ff <= cnt_ff + 5'h01;
					end
					cmc_pkg::SG_TWO: begin
						if (edge_now && (rem2 <= rjw_w)) begin
							seg_ff <= cmc_pkg::SG_ONE; // RULE24
							cnt_ff <= 5'h00;
							lim_ff <= {1'b0, bs1};
						end else if (edge_now)
							cnt_ff <= cnt_ff + rjw_w;
						else if (cnt_ff == {2'b00, bs2})
							seg_ff <= cmc_pkg::SG_SYNC;
						else
							cnt_ff <= cnt_ff + 5'h01;
					end
					default: seg_ff <= cmc_pkg::SG_SYNC;
				endcase
			end
		end
	end

	// wake pulse length: sync + bs1+1 + bs2+1 quanta
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			wk_cnt_ff <= 5'h00;
		else if (state_ff != cmc_pkg::ST_WAKE)
			wk_cnt_ff <= 5'h00;
		else if (tq)
			wk_cnt_ff <= wk_cnt_ff + 5'h01;
	end
	assign wake_done = tq && (wk_cnt_ff == ({1'b0, bs1} + {2'b00, bs2} + 5'h02)); // RULE5

	// recessive run and sequence counting during resync
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			run_ff <= 4'h0;
			seq_ff <= 8'h00;
		end else if (state_ff != cmc_pkg::ST_RESYNC) begin
			run_ff <= 4'h0;
			seq_ff <= 8'h00;
		end else if (sample) begin
			if (!rx_sync_ff)
				run_ff <= 4'h0;
			else if (run_ff == cmc_pkg::RUN_LAST) begin
				run_ff <= 4'h0;
				seq_ff <= seq_ff + 8'h01; // RULE6
			end else
				run_ff <= run_ff + 4'h1;
		end
	end
	assign seq_done = sample && (state_ff == cmc_pkg::ST_RESYNC) && rx_sync_ff && (run_ff == cmc_pkg::RUN_LAST)
		&& ((seq_ff == cmc_pkg::SEQ_LAST) || (fast_sync_select && !bus_off)); // RULE6

	// transmit selection, buffer 3 first
	assign pend = lock_ff & rdy_ff & job_ff;
	assign hi   = pend[2] ? 2'd2 : (pend[1] ? 2'd1 : 2'd0);
	assign sel  = (early_transmit && arm_ff && pend[arm_buf_ff]) ? arm_buf_ff : hi; // RULE14

	// mode sequencer
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			state_ff <= cmc_pkg::ST_STANDBY; // RULE1
		else if (bus_off && (state_ff != cmc_pkg::ST_STANDBY) && (state_ff != cmc_pkg::ST_RESYNC))
			state_ff <= cmc_pkg::ST_RESYNC;
		else begin
			case (state_ff)
				cmc_pkg::ST_STANDBY:
					if (run_req)
						state_ff <= wake_pulse_select ? cmc_pkg::ST_WAKE : cmc_pkg::ST_RESYNC; // RULE3
				cmc_pkg::ST_WAKE:
					if (wake_done)
						state_ff <= cmc_pkg::ST_RESYNC;
				cmc_pkg::ST_RESYNC:
					if (seq_done)
						state_ff <= cmc_pkg::ST_IDLE; // RULE4
				cmc_pkg::ST_IDLE: begin
					if (!run_req)
						state_ff <= cmc_pkg::ST_STANDBY; // RULE7
					else if (|pend)
						state_ff <= cmc_pkg::ST_TX; // RULE9
					else if (sample && !rx_sync_ff)
						state_ff <= cmc_pkg::ST_RX; // RULE7
				end
				cmc_pkg::ST_TX: begin
					if (FRM_ARB_LOST)
						state_ff <= cmc_pkg::ST_RX; // RULE10
					else if (FRM_TX_OK || FRM_TX_ERR)
						state_ff <= cmc_pkg::ST_IDLE;
				end
				cmc_pkg::ST_RX:
					if (FRM_END)
						state_ff <= cmc_pkg::ST_IDLE;
				default: state_ff <= cmc_pkg::ST_STANDBY;
			endcase
		end
	end

	// job start strobe and sticky arbitration buffer
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tx_start_ff <= 1'b0;
			cur_ff      <= 2'd0;
			arm_ff      <= 1'b0;
			arm_buf_ff  <= 2'd0;
		end else begin
			tx_start_ff <= (state_ff == cmc_pkg::ST_IDLE) && run_req && !bus_off && (|pend);
			if ((state_ff == cmc_pkg::ST_IDLE) && (|pend)) begin
				cur_ff     <= sel;
				arm_ff     <= 1'b1; // RULE14
				arm_buf_ff <= sel;
			end else if ((in_tx && FRM_ARB_WON) || !pend[arm_buf_ff])
				arm_ff <= 1'b0;
		end
	end

	// register writes; timing only in standby
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			icr_ff  <= 8'h00;
			csr_ff  <= 5'h00;
			pre_ff  <= cmc_pkg::PRE_RST;
			btr_ff  <= cmc_pkg::BTR_RST;
			page_ff <= 3'h0;
		end else if (WR_EN) begin
			case (ADDR)
				cmc_pkg::A_ICR:  icr_ff  <= {1'b0, WR_DATA[6:0]};
				cmc_pkg::A_CSR:  csr_ff  <= WR_DATA[4:0]; // RULE1
				cmc_pkg::A_PRE:  if (standby) pre_ff <= WR_DATA; // RULE22
				cmc_pkg::A_BTR:  if (standby) btr_ff <= {1'b0, WR_DATA[6:0]}; // RULE22
				cmc_pkg::A_PAGE: page_ff <= WR_DATA[2:0];
				default: ;
			endcase
		end
	end

	// receive target: first free buffer from 1 to 3
	assign free       = ~lock_ff & ~rdy_ff;
	assign any_free   = |free;
	assign first_free = free[0] ? 2'd0 : (free[1] ? 2'd1 : 2'd2); // RULE16
	assign store_ev   = (state_ff == cmc_pkg::ST_RX) && FRM_RX_OK && (!FRM_RX_OWN || self_receive_enable); // RULE15
	assign wr_bcs     = WR_EN && (ADDR >= cmc_pkg::A_BCS1) && (ADDR < cmc_pkg::A_LAST);
	assign wr_idx     = 2'(ADDR - cmc_pkg::A_BCS1);
	assign submit     = WR_EN && (ADDR == cmc_pkg::A_LAST) && (page_ff >= 3'h1) && (page_ff <= 3'h3);

	// per buffer lock, ready, busy, filter number, receive flag
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			lock_ff <= 3'h0;
			rdy_ff  <= 3'h0;
			job_ff  <= 3'h0;
			busy_ff <= 3'h0;
			acc_ff  <= 3'h0;
			receive_flag_ff <= 3'h0;
		end else begin
			for (int i = 0; i < 3; i++) begin
				busy_ff[i] <= in_tx && (cur_ff == 2'(i)) && !(FRM_ARB_LOST || FRM_TX_OK || FRM_TX_ERR); // RULE11
				if (wr_bcs && (wr_idx == 2'(i))) begin
					lock_ff[i] <= WR_DATA[cmc_pkg::B_LOCK];
					if (!WR_DATA[cmc_pkg::B_RDY]) begin
						rdy_ff[i]  <= 1'b0;
						job_ff[i]  <= 1'b0;
						receive_flag_ff[i] <= 1'b0;
					end
				end
				if (WR_EN && (ADDR == cmc_pkg::A_ISR) && !WR_DATA[cmc_pkg::F_RECEIVE_FLAG + i])
					receive_flag_ff[i] <= 1'b0;
				// job ends: done, unlocked, refused retry, bus-off
				if (job_ff[i] && ((tx_ok && (cur_ff == 2'(i))) || !lock_ff[i] || bus_off
						|| (tx_err && no_retransmission && (cur_ff == 2'(i))))) begin
					rdy_ff[i] <= 1'b0; // RULE10
					job_ff[i] <= 1'b0; // RULE11
				end
				if (tx_ok && early_transmit && (cur_ff == 2'(i)))
					lock_ff[i] <= 1'b0; // RULE13
				if (submit && (page_ff == 3'(i + 1)) && lock_ff[i]) begin
					rdy_ff[i] <= 1'b1; // RULE8
					job_ff[i] <= 1'b1;
				end
				if (store_ev && any_free && (first_free == 2'(i))) begin
					rdy_ff[i]  <= 1'b1; // RULE18
					receive_flag_ff[i] <= 1'b1;
					acc_ff[i]  <= FRM_RX_FILT;
				end
			end
		end
	end

	// error counters and status change memory
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			tec_ff  <= 9'h000;
			rec_ff  <= 8'h00;
			stat_ff <= 2'b00;
		end else begin
			stat_ff <= {bus_off, err_psv};
			if (bus_off && seq_done) begin
				tec_ff <= 9'h000; // RULE19
				rec_ff <= 8'h00;
			end else begin
				if (tx_err)
					tec_ff <= tec_ff + cmc_pkg::TEC_STEP; // RULE19
				else if (tx_ok && (tec_ff != 9'h000))
					tec_ff <= tec_ff - 9'h001;
				if (FRM_RX_ERR && (rec_ff != cmc_pkg::REC_MAX))
					rec_ff <= rec_ff + 8'h01;
				else if (FRM_RX_OK && (rec_ff != 8'h00))
					rec_ff <= rec_ff - 8'h01;
			end
		end
	end

	// interrupt flags: software writes 0 to clear, hardware set wins
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			transmit_done_flag_ff <= 1'b0;
			scif_ff <= 1'b0;
			orif_ff <= 1'b0;
			transmit_error_flag_ff <= 1'b0;
			lid_ff  <= 11'h000;
		end else begin
			if (WR_EN && (ADDR == cmc_pkg::A_ISR)) begin
				transmit_done_flag_ff <= transmit_done_flag_ff & WR_DATA[cmc_pkg::F_TRANSMIT_DONE_FLAG];
				scif_ff <= scif_ff & WR_DATA[cmc_pkg::F_SCIF];
				orif_ff <= orif_ff & WR_DATA[cmc_pkg::F_ORIF];
				transmit_error_flag_ff <= transmit_error_flag_ff & WR_DATA[cmc_pkg::F_TRANSMIT_ERROR_FLAG];
			end
			if ((tx_ok && !early_transmit) || (in_tx && FRM_ARB_WON && early_transmit))
				transmit_done_flag_ff <= 1'b1; // RULE12 RULE13
			if (tx_err)
				transmit_error_flag_ff <= 1'b1; // RULE12
			if ((standby && fall) || (stat_ff != {bus_off, err_psv}) || (icr_ff[cmc_pkg::C_ESCI] && FRM_RX_ERR))
				scif_ff <= 1'b1; // RULE2 RULE19
			if (store_ev && !any_free)
				orif_ff <= 1'b1; // RULE17
			if (store_ev)
				lid_ff <= FRM_RX_ID; // RULE17
		end
	end

	// single interrupt line and bus driver
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			irq_ff    <= 1'b0;
			can_tx_ff <= 1'b1;
		end else begin
			irq_ff <= (|receive_flag_ff && icr_ff[cmc_pkg::C_RECEIVE_IRQ_ENABLE]) || (transmit_done_flag_ff && icr_ff[cmc_pkg::C_TRANSMIT_DONE_IRQ_ENABLE])
				|| (scif_ff && icr_ff[cmc_pkg::C_STATUS_CHANGE_IRQ_ENABLE]) || (orif_ff && icr_ff[cmc_pkg::C_OVERRUN_IRQ_ENABLE])
				|| (transmit_error_flag_ff && icr_ff[cmc_pkg::C_TRANSMIT_ERROR_IRQ_ENABLE]); // RULE12 RULE2
			if (state_ff == cmc_pkg::ST_WAKE)
				can_tx_ff <= 1'b0; // RULE5
			else
				can_tx_ff <= in_tx ? FRM_TX_BIT : 1'b1;
		end
	end

	// sample strobe to the frame engine
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			bit_sample_ff <= 1'b0;
			rx_bit_ff     <= 1'b1;
		end else begin
			bit_sample_ff <= sample; // RULE20
			if (sample)
				rx_bit_ff <= rx_sync_ff;
		end
	end

	// read path, data valid in the following cycle only
	assign tec_rd = bus_off ? 8'hFF : tec_ff[7:0];
	always_comb begin
		rd_mux = 8'h00;
		case (ADDR)
			cmc_pkg::A_ISR:  rd_mux = {receive_flag_ff[2], receive_flag_ff[1], receive_flag_ff[0], transmit_done_flag_ff, scif_ff, orif_ff, transmit_error_flag_ff,
				scif_ff | orif_ff | transmit_error_flag_ff};
			cmc_pkg::A_ICR:  rd_mux = icr_ff;
			cmc_pkg::A_CSR:  rd_mux = {1'b0, bus_off, err_psv, csr_ff[4:1], run_req | !standby}; // RULE1
			cmc_pkg::A_PRE:  rd_mux = pre_ff;
			cmc_pkg::A_BTR:  rd_mux = btr_ff;
			cmc_pkg::A_PAGE: rd_mux = {5'h00, page_ff};
			cmc_pkg::A_TEC:  rd_mux = tec_rd; // RULE19
			cmc_pkg::A_REC:  rd_mux = rec_ff;
			cmc_pkg::A_LIDH: rd_mux = lid_ff[10:3];
			cmc_pkg::A_LIDL: rd_mux = {lid_ff[2:0], 5'h00};
			default: begin
				if ((ADDR >= cmc_pkg::A_BCS1) && (ADDR < cmc_pkg::A_LAST))
					rd_mux = {4'h0, acc_ff[wr_idx], busy_ff[wr_idx], rdy_ff[wr_idx], lock_ff[wr_idx]};
			end
		endcase
	end
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST)
			rd_data_ff <= 8'h00;
		else
			rd_data_ff <= RD_EN ? rd_mux : 8'h00;
	end

	assign RD_DATA    = rd_data_ff;
	assign CAN_TX     = can_tx_ff;
	assign IRQ        = irq_ff;
	assign BIT_SAMPLE = bit_sample_ff;
	assign RX_BIT     = rx_bit_ff;
	assign TX_START   = tx_start_ff;
	assign TX_BUF     = cur_ff;

	// checks
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!NRST);
	sequence s_standby_run;
		standby && run_req;
	endsequence
	sequence s_tx_fail;
		in_tx && FRM_TX_ERR && !FRM_ARB_LOST;
	endsequence
	standby_entry_a: assert property (in_tx |=> !standby) // RULE1
		else $error("standby entered during transfer");
	wake_flag_a: assert property (standby && fall |=> scif_ff) // RULE2
		else $error("wake-up flag missed");
	leave_standby_a: assert property (s_standby_run |=> (state_ff == (wake_pulse_select ? cmc_pkg::ST_WAKE : cmc_pkg::ST_RESYNC))) // RULE3
		else $error("wrong exit from standby");
	wake_drive_a: assert property ($rose(state_ff == cmc_pkg::ST_WAKE) |=> !CAN_TX [*2]) // RULE5
		else $error("wake pulse not dominant");
	resync_hold_a: assert property ((state_ff == cmc_pkg::ST_RESYNC) && !seq_done && !bus_off
		|=> state_ff != cmc_pkg::ST_IDLE) // RULE6
		else $error("idle without resync");
	tx_priority_a: assert property ((state_ff == cmc_pkg::ST_IDLE) && run_req && !bus_off && pend[2] && !arm_ff
		|=> TX_START && (TX_BUF == 2'd2)) // RULE9
		else $error("buffer 3 not chosen");
	busy_hold_a: assert property (in_tx ##1 in_tx |-> busy_ff[cur_ff]) // RULE11
		else $error("busy flag not held");
	tx_error_a: assert property (s_tx_fail |=> transmit_error_flag_ff && (state_ff != cmc_pkg::ST_TX)) // RULE12
		else $error("transmit error flag missing");
	timing_lock_a: assert property (!standby && WR_EN && (ADDR == cmc_pkg::A_BTR) |=> $stable(btr_ff)) // RULE22
		else $error("timing written outside standby");
	quantum_gap_a: assert property (tq && (quantum_prescaler != 6'h00) |=> !tq) // RULE23
		else $error("quantum too short");
	rx_store_a: assert property (store_ev && free[0] && !(wr_bcs && wr_idx == 2'd0) |=> rdy_ff[0] && receive_flag_ff[0]) // RULE16
		else $error("first free buffer not filled");
	overrun_a: assert property (store_ev && !any_free |=> orif_ff && (lid_ff == $past(FRM_RX_ID))) // RULE17
		else $error("overrun not signalled");
endmodule // cmc_mode_ctrl

// [bench/cmc_bus_node.sv]
// other nodes on the bus: wired-and line with a dominant pulse on request
`timescale 1ns/10ps
module cmc_bus_node (
	input  wire logic DUT_TX,
	input  wire logic DOM,
	output logic      BUS
);
	// open-drain bus, recessive unless a node pulls it low
	assign BUS = DUT_TX & ~DOM;
endmodule // cmc_bus_node

// [bench/cmc_mode_ctrl_tb.sv]
// self-checking bench of the protocol mode controller
`timescale 1ns/10ps
module cmc_mode_ctrl_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        we = 1'b0;
	logic        re = 1'b0;
	logic        dom = 1'b0;
	logic        filt = 1'b1;
	logic        can_rx, can_tx, irq, bsmp, rxbit, txs;
	logic [1:0]  txbuf;
	logic [3:0]  addr = 4'h0;
	logic [7:0]  wdat = 8'h00;
	logic [7:0]  frm = 8'h00;
	logic [7:0]  rdat, v;
	logic [10:0] id = 11'h000;
	logic [3:0]  ra[8] = '{cmc_pkg::A_ISR, cmc_pkg::A_ICR, cmc_pkg::A_CSR, cmc_pkg::A_PRE,
	                       cmc_pkg::A_BTR, cmc_pkg::A_TEC, cmc_pkg::A_REC, 4'hE};
	logic [7:0]  rv[8] = '{8'h00, 8'h00, 8'h00, cmc_pkg::PRE_RST, cmc_pkg::BTR_RST, 8'h00, 8'h00, 8'h00};
	logic [3:0]  jb[2] = '{4'h1, 4'h3};
	int          fail_count = 0;
	int          n_tests = 0;
	int          n;

	// 125 MHz clock
	always #4 clk = ~clk;

	cmc_mode_ctrl dut_u (.CLOCK(clk), .NRST(nrst), .ADDR(addr), .WR_DATA(wdat), .WR_EN(we), .RD_EN(re),
		.RD_DATA(rdat), .CAN_RX(can_rx), .CAN_TX(can_tx), .IRQ(irq), .BIT_SAMPLE(bsmp), .RX_BIT(rxbit),
		.TX_START(txs), .TX_BUF(txbuf), .FRM_TX_BIT(1'b1), .FRM_ARB_WON(frm[0]), .FRM_ARB_LOST(frm[1]),
		.FRM_TX_OK(frm[2]), .FRM_TX_ERR(frm[3]), .FRM_RX_OK(frm[4]), .FRM_RX_ERR(frm[5]), .FRM_RX_OWN(frm[6]),
		.FRM_RX_FILT(filt), .FRM_RX_ID(id), .FRM_END(frm[7]));
	cmc_bus_node node_u (.DUT_TX(can_tx), .DOM(dom), .BUS(can_rx));

	// clocks in one bit: quantum is brp+1 clocks, bit is 3+bs1+bs2 quanta
	function automatic logic [7:0] bit_clk(input logic [7:0] p, input logic [7:0] b);
		return 8'((8'd3 + b[3:0] + b[6:4]) * (p[5:0] + 8'd1));
	endfunction

	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// register bus cycles
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		we   <= 1'b1;
		@(posedge clk);
		we   <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		re   <= 1'b1;
		@(posedge clk);
		re   <= 1'b0;
		#1 v = rdat;
	endtask

	// one-cycle frame engine pulse
	task automatic pulse(input int i);
		@(posedge clk);
		frm[i] <= 1'b1;
		@(posedge clk);
		frm[i] <= 1'b0;
	endtask

	// wait for a job start and check its buffer
	task automatic wait_tx(input logic [1:0] b);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (txs !== 1'b1 && n < 3000);
		chk({7'h0, txs}, 8'h01);
		chk({6'h0, txbuf}, {6'h0, b});
	endtask

	// dominant start bit from a remote node, then an accepted message
	task automatic rx_msg();
		@(posedge clk);
		dom <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (!(bsmp === 1'b1 && rxbit === 1'b0) && n < 500);
		chk({6'h0, bsmp, rxbit}, 8'h02);
		@(posedge clk);
		dom <= 1'b0;
		id  <= 11'($urandom);
		repeat (2) @(posedge clk);
		pulse(4);
		pulse(7);
		repeat (4) @(posedge clk);
	endtask

	// verdict, the single exit of the run
	task automatic end_sim();
		$display("tests %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_sim();
	end

	// main sequence
	initial begin
		v = 8'($urandom(96727));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(v, rv[i]);
		end
		wr(cmc_pkg::A_PRE, 8'h01);
		wr(cmc_pkg::A_BTR, 8'h12);
		rd(cmc_pkg::A_BTR);
		chk(v, 8'h12);
		wr(cmc_pkg::A_ICR, 8'h08);
		@(posedge clk);
		dom <= 1'b1;
		repeat (4) @(posedge clk);
		dom <= 1'b0;
		repeat (4) @(posedge clk);
		rd(cmc_pkg::A_ISR);
		chk(v & 8'h08, 8'h08);
		chk({7'h0, irq}, 8'h01);
		wr(cmc_pkg::A_ISR, 8'h00);
		// lock, read back, submit jobs on buffers 1 and 3
		foreach (jb[i]) begin
			wr(cmc_pkg::A_BCS1 + jb[i] - 4'h1, 8'h01);
			rd(cmc_pkg::A_BCS1 + jb[i] - 4'h1);
			chk(v, 8'h01);
			wr(cmc_pkg::A_PAGE, {4'h0, jb[i]});
			wr(cmc_pkg::A_LAST, 8'($urandom));
		end
		wr(cmc_pkg::A_ICR, 8'h1A);
		wr(cmc_pkg::A_CSR, 8'h07);
		n = 0;
		while (can_tx !== 1'b0 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		while (can_tx === 1'b0 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		chk(8'(n), bit_clk(8'h01, 8'h12));
		wait_tx(2'd2);
		rd(cmc_pkg::A_BCS1 + 4'h2);
		chk(v & 8'h04, 8'h04);
		pulse(3);
		wait_tx(2'd2);
		rd(cmc_pkg::A_ISR);
		chk(v & 8'h02, 8'h02);
		pulse(2);
		wait_tx(2'd0);
		rd(cmc_pkg::A_ISR);
		chk(v & 8'h10, 8'h10);
		rd(cmc_pkg::A_BCS1 + 4'h2);
		chk(v & 8'h06, 8'h00);
		pulse(2);
		wr(cmc_pkg::A_ISR, 8'h00);
		wr(cmc_pkg::A_ICR, 8'h24);
		// buffers 1 and 3 locked: first message lands in buffer 2
		rx_msg();
		rd(cmc_pkg::A_BCS1 + 4'h1);
		chk(v, 8'h0A);
		rd(cmc_pkg::A_ISR);
		chk(v & 8'h40, 8'h40);
		rx_msg();
		rd(cmc_pkg::A_ISR);
		chk(v & 8'h04, 8'h04);
		rd(cmc_pkg::A_LIDH);
		chk(v, id[10:3]);
		rd(cmc_pkg::A_LIDL);
		chk(v & 8'hE0, {id[2:0], 5'h00});
		// early transmit on buffer 1: flag on won arbitration, unlock on success
		wr(cmc_pkg::A_ICR, 8'h01);
		rd(cmc_pkg::A_BCS1);
		chk(v, 8'h01);
		wr(cmc_pkg::A_PAGE, 8'h01);
		wr(cmc_pkg::A_LAST, 8'($urandom));
		wait_tx(2'd0);
		pulse(0);
		rd(cmc_pkg::A_ISR);
		chk(v & 8'h10, 8'h10);
		pulse(2);
		rd(cmc_pkg::A_BCS1);
		chk(v & 8'h07, 8'h00);
		// own frame without self receive: buffer 1 stays free
		frm[6] <= 1'b1;
		rx_msg();
		frm[6] <= 1'b0;
		rd(cmc_pkg::A_BCS1);
		chk(v & 8'h02, 8'h00);
		wr(cmc_pkg::A_BTR, 8'h34);
		rd(cmc_pkg::A_BTR);
		chk(v, 8'h12);
		wr(cmc_pkg::A_CSR, 8'h00);
		repeat (20) @(posedge clk);
		rd(cmc_pkg::A_CSR);
		chk(v & 8'h01, 8'h00);
		end_sim();
	end
endmodule // cmc_mode_ctrl_tb
